//--- hdl/dts_pkg.sv
// Function
// [RQ1] Count tone periods digitally; accept only the standard eight signalling frequencies.
// [RQ2] Early steering active while both groups hold valid tones; drops on loss.
// [RQ3] After the full present guard time, register pair and latch its 4-bit code.
// [RQ4] Guard-time output stays high while early steering stays active.
// [RQ5] Delayed steering rises only after a settling delay following the latch.
// [RQ6] Delayed steering means tones present or absent for the guard time.
// [RQ7] Receive data latch updates only on a rising delayed steering transition.
// [RQ8] Bursts failing the present guard leave the receive data unchanged.
// [RQ9] A pair passing validation is decoded and stored in receive data.
// [RQ10] After a valid pause the code is kept until the next registered pair.
// [RQ11] Dropouts shorter than the absent guard change neither data nor steering.
// [RQ12] Same guard check in reverse validates pauses; short gaps and tones rejected.
// [RQ13] Delayed steering state is readable as a status bit.
// [RQ14] Data-valid status bit sets on new data, clears after status read.
// [RQ15] In interrupt mode the interrupt pin is low while delayed steering is active.
// [RQ16] A status read releases the interrupt; host reads status per digit.
// [RQ17] Reading receive data returns the latched 4-bit code on the bus.
// [RQ18] Host sees one status, two control and two data registers.
// [RQ19] Digits 1-9 as 1-9, 0 as a, star b, hash c, A-C d-f, D 0.
// [RQ20] Tone presence is detected within 5 to 14 ms before the guard starts.
// [RQ21] Delayed steering follows the guard threshold crossing by about 13 us.
// [RQ22] Present and absent guard times are configurable cycle counters.
//
// Purpose: Shared constants and types of the tone receive steering block.
// Assumes: 100 MHz reference clock, Avalon-MM slave with 32-bit data.
// Notes: Offsets are byte addresses.
package dts_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_NS = 10;
  localparam int PER_W = 18;
  localparam int GUARD_W = 24;
  localparam int TOL_PERMIL = 25;
  localparam logic [PER_W-1:0] PER_TIMEOUT = 18'h27100;
  localparam logic [1:0] MATCH_LAST = 2'h3;
  localparam int TONE_HZ [8] = '{697, 770, 852, 941, 1209, 1336, 1477, 1633};
  localparam int GTP_US = 25000;
  localparam int GTA_US = 25000;
  localparam int GTP_CYC = GTP_US * 1000 / CLK_NS;
  localparam int GTA_CYC = GTA_US * 1000 / CLK_NS;
  localparam int SETTLE_NS = 13000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [63:0] DIGIT_LUT = 64'h0cab_f987_e654_d321;
  localparam logic [5:0] OFF_RX_DATA = 6'h00;
  localparam logic [5:0] OFF_TX_DATA = 6'h04;
  localparam logic [5:0] OFF_STATUS = 6'h08;
  localparam logic [5:0] OFF_CTRL_A = 6'h0c;
  localparam logic [5:0] OFF_CTRL_B = 6'h10;
  localparam logic [5:0] OFF_GTP = 6'h14;
  localparam logic [5:0] OFF_GTA = 6'h18;
  localparam int ST_DV_BIT = 2;
  localparam int ST_DS_BIT = 3;
  localparam int ST_ES_BIT = 4;
  localparam int STEER_IN_GUARD_OUT_BIT = 5;
  localparam int CA_IRQ_BIT = 0;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [3:0] CODE_RST = 4'h0;

  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
  } dts_avs_req_s;

  typedef struct packed {
    logic es;
    logic gt;
    logic ds;
    logic dv;
  } dts_rx_state_s;

  // Period window of table tone i, in cycles of a clock running at hz
  function automatic logic [PER_W-1:0] per_min(input int i, input int hz);
    per_min = PER_W'((hz / TONE_HZ[i]) * (1000 - TOL_PERMIL) / 1000);
  endfunction

  function automatic logic [PER_W-1:0] per_max(input int i, input int hz);
    per_max = PER_W'((hz / TONE_HZ[i]) * (1000 + TOL_PERMIL) / 1000);
  endfunction
endpackage

//--- hdl/dts_steering.sv
// Purpose: Tone detection, guard-time steering, receive data and host registers.
// Assumes: Limited low and high group tone square waves arrive asynchronously.
// Notes: All state freezes while clk_en is low.
`timescale 1ns/1ps
module dts_steering #(
  parameter logic [23:0] GTP_DEFAULT = 24'(dts_pkg::GTP_CYC),
  parameter logic [23:0] GTA_DEFAULT = 24'(dts_pkg::GTA_CYC),
  parameter int REF_CLK_HZ = dts_pkg::CLK_HZ
) (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic resetn, // Async reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic [1:0] tone_sq, // Limited tones: 0 low group, 1 high group
  input wire dts_pkg::dts_avs_req_s avs_req, // Avalon request group
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon wait request
  output logic early_steering, // Both tones valid
  output logic steer_in_guard_out, // Guarded steering state
  output logic delayed_steering_bit, // Registered pair, settled
  output logic interrupt_progress_pin_n // Interrupt, active low
);
  ////////////////////////////////////////////////////////////////////////////
  // Tone period measurement, one channel per group
  // Windows and the no-edge timeout follow the clock rate the block is built for
  localparam int PER_W_L = dts_pkg::PER_W;
  localparam logic [PER_W_L-1:0] PER_TO_L =
    PER_W_L'(64'(dts_pkg::PER_TIMEOUT) * 64'(REF_CLK_HZ) / 64'(dts_pkg::CLK_HZ));
  logic [1:0] tone_valid;
  logic [1:0] tone_idx [2];

  for (genvar g = 0; g < 2; g++) begin : g_grp
    logic [2:0] sq_reg;
    logic [PER_W_L-1:0] per_reg;
    logic [PER_W_L-1:0] per_next;
    logic [1:0] idx_reg;
    logic [1:0] idx_next;
    logic [1:0] run_reg;
    logic [1:0] run_next;
    logic val_reg;
    logic val_next;
    logic hit;
    logic [1:0] hit_idx;

    always_comb begin
      hit = 1'b0;
      hit_idx = 2'h0;
      for (int i = 0; i < 4; i++) begin
        if (per_reg >= dts_pkg::per_min(g * 4 + i, REF_CLK_HZ) &&
            per_reg <= dts_pkg::per_max(g * 4 + i, REF_CLK_HZ)) begin
          hit = 1'b1; // RQ1
          hit_idx = 2'(i);
        end
      end
    end

    always_comb begin
      per_next = per_reg;
      idx_next = idx_reg;
      run_next = run_reg;
      val_next = val_reg;
      if (sq_reg[1] && !sq_reg[2]) begin
        per_next = '0;
        if (hit && hit_idx == idx_reg) begin
          if (run_reg != dts_pkg::MATCH_LAST) begin
            run_next = run_reg + 2'h1;
          end
          val_next = (run_reg == dts_pkg::MATCH_LAST); // RQ20
        end else begin
          idx_next = hit_idx;
          run_next = '0;
          val_next = 1'b0; // RQ1
        end
      end else if (per_reg == PER_TO_L) begin
        run_next = '0;
        val_next = 1'b0;
      end else begin
        per_next = per_reg + 18'h1;
      end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        sq_reg <= '0;
        per_reg <= '0;
        idx_reg <= '0;
        run_reg <= '0;
        val_reg <= 1'b0;
      end else if (clk_en) begin
        sq_reg <= {sq_reg[1:0], tone_sq[g]};
        per_reg <= per_next;
        idx_reg <= idx_next;
        run_reg <= run_next;
        val_reg <= val_next;
      end
    end

    assign tone_valid[g] = val_reg;
    assign tone_idx[g] = idx_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Steering, guard timing and receive data
  logic es_reg, es_next;
  logic gt_reg, gt_next;
  logic ds_reg, ds_next;
  logic dv_reg, dv_next;
  logic pend_reg, pend_next;
  logic [23:0] gcnt_reg, gcnt_next;
  logic [11:0] settle_reg, settle_next;
  logic [3:0] held_reg, held_next;
  logic [3:0] rx_reg, rx_next;
  logic [3:0] cur_code;
  logic [23:0] gtp_reg, gtp_next;
  logic [23:0] gta_reg, gta_next;
  logic [23:0] glim;
  logic stat_rd;
  dts_pkg::dts_rx_state_s rx_state;

  assign cur_code = dts_pkg::DIGIT_LUT[{tone_idx[0], tone_idx[1], 2'h0} +: 4]; // RQ19
  assign glim = gt_reg ? gta_reg : gtp_reg;

  always_comb begin
    es_next = tone_valid[0] & tone_valid[1]; // RQ2
    gt_next = gt_reg;
    gcnt_next = '0;
    held_next = held_reg;
    if (es_reg != gt_reg) begin
      if (gcnt_reg + 24'h1 >= glim) begin
        gt_next = es_reg; // RQ3 RQ4 RQ12 RQ22
        if (es_reg) begin
          held_next = cur_code; // RQ3 RQ9
        end
      end else begin
        gcnt_next = gcnt_reg + 24'h1; // RQ11 RQ8
      end
    end
  end

  always_comb begin
    ds_next = ds_reg;
    settle_next = '0;
    rx_next = rx_reg;
    dv_next = dv_reg;
    pend_next = pend_reg;
    if (stat_rd) begin
      dv_next = 1'b0; // RQ14
      pend_next = 1'b0; // RQ16
    end
    if (!gt_reg) begin
      ds_next = 1'b0; // RQ6
    end else if (!ds_reg) begin
      if (settle_reg == 12'(dts_pkg::SETTLE_CYC - 1)) begin
        ds_next = 1'b1; // RQ5 RQ21
        rx_next = held_reg; // RQ7 RQ10
        dv_next = 1'b1; // RQ14
        pend_next = 1'b1; // RQ15
      end else begin
        settle_next = settle_reg + 12'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      es_reg <= 1'b0;
      gt_reg <= 1'b0;
      gcnt_reg <= '0;
      held_reg <= dts_pkg::CODE_RST;
      ds_reg <= 1'b0;
      settle_reg <= '0;
      rx_reg <= dts_pkg::CODE_RST;
      dv_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else if (clk_en) begin
      es_reg <= es_next;
      gt_reg <= gt_next;
      gcnt_reg <= gcnt_next;
      held_reg <= held_next;
      ds_reg <= ds_next;
      settle_reg <= settle_next;
      rx_reg <= rx_next;
      dv_reg <= dv_next;
      pend_reg <= pend_next;
    end
  end

  assign rx_state = '{es: es_reg, gt: gt_reg, ds: ds_reg, dv: dv_reg};

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, effects at the accepting edge
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [3:0] ctrl_a_reg, ctrl_a_next;
  logic [3:0] ctrl_b_reg, ctrl_b_next;
  logic [3:0] tx_reg, tx_next;
  logic irq_n_reg, irq_n_next;
  logic req;
  logic acc;

  assign req = avs_req.read | avs_req.write;
  assign acc = req & !wait_reg;
  assign stat_rd = acc & avs_req.read & (avs_req.address == dts_pkg::OFF_STATUS); // RQ16

  always_comb begin
    wait_next = !(req & wait_reg);
    rdata_next = rdata_reg;
    ctrl_a_next = ctrl_a_reg;
    ctrl_b_next = ctrl_b_reg;
    tx_next = tx_reg;
    gtp_next = gtp_reg;
    gta_next = gta_reg;
    if (req && wait_reg && avs_req.read) begin
      rdata_next = '0;
      case (avs_req.address) // RQ18
        dts_pkg::OFF_RX_DATA: rdata_next[3:0] = rx_reg; // RQ17
        dts_pkg::OFF_TX_DATA: rdata_next[3:0] = tx_reg;
        dts_pkg::OFF_STATUS: begin
          rdata_next[dts_pkg::ST_DV_BIT] = rx_state.dv; // RQ14
          rdata_next[dts_pkg::ST_DS_BIT] = rx_state.ds; // RQ13
          rdata_next[dts_pkg::ST_ES_BIT] = rx_state.es;
          rdata_next[dts_pkg::STEER_IN_GUARD_OUT_BIT] = rx_state.gt;
        end
        dts_pkg::OFF_CTRL_A: rdata_next[3:0] = ctrl_a_reg;
        dts_pkg::OFF_CTRL_B: rdata_next[3:0] = ctrl_b_reg;
        dts_pkg::OFF_GTP: rdata_next[23:0] = gtp_reg;
        dts_pkg::OFF_GTA: rdata_next[23:0] = gta_reg;
        default: rdata_next = '0;
      endcase
    end
    if (acc && avs_req.write) begin
      case (avs_req.address)
        dts_pkg::OFF_TX_DATA: tx_next = avs_req.writedata[3:0];
        dts_pkg::OFF_CTRL_A: ctrl_a_next = avs_req.writedata[3:0];
        dts_pkg::OFF_CTRL_B: ctrl_b_next = avs_req.writedata[3:0];
        dts_pkg::OFF_GTP: gtp_next = avs_req.writedata[23:0]; // RQ22
        dts_pkg::OFF_GTA: gta_next = avs_req.writedata[23:0]; // RQ22
        default: tx_next = tx_reg;
      endcase
    end
    irq_n_next = !(ctrl_a_reg[dts_pkg::CA_IRQ_BIT] & ds_reg & pend_reg); // RQ15 RQ16
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= 1'b1;
      rdata_reg <= '0;
      ctrl_a_reg <= dts_pkg::CTRL_RST;
      ctrl_b_reg <= dts_pkg::CTRL_RST;
      tx_reg <= dts_pkg::CODE_RST;
      gtp_reg <= GTP_DEFAULT;
      gta_reg <= GTA_DEFAULT;
      irq_n_reg <= 1'b1;
    end else if (clk_en) begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      ctrl_a_reg <= ctrl_a_next;
      ctrl_b_reg <= ctrl_b_next;
      tx_reg <= tx_next;
      gtp_reg <= gtp_next;
      gta_reg <= gta_next;
      irq_n_reg <= irq_n_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign early_steering = es_reg;
  assign steer_in_guard_out = gt_reg;
  assign delayed_steering_bit = ds_reg;
  assign interrupt_progress_pin_n = irq_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int SETTLE_LAST = dts_pkg::SETTLE_CYC - 1;

  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  a_es_follows_tones: assert property ( // RQ2
    clk_en |=> es_reg == $past(tone_valid[0] & tone_valid[1]))
    else $error("early steering does not follow tone validity");
  a_gt_guard_rise: assert property ( // RQ3
    clk_en && !gt_reg && es_reg && gcnt_reg + 24'h1 >= gtp_reg |=> gt_reg && held_reg == $past(cur_code))
    else $error("pair not registered at guard end");
  a_gt_holds_es: assert property ( // RQ4
    clk_en && gt_reg && es_reg |=> gt_reg)
    else $error("guard output dropped while tone present");
  a_dropout_kept: assert property ( // RQ11
    clk_en && gt_reg && !es_reg && gcnt_reg + 24'h1 < gta_reg |=> gt_reg && $stable(rx_reg))
    else $error("short dropout changed steering");
  a_ds_settle_time: assert property ( // RQ5
    $rose(ds_reg) |-> $past(settle_reg) == 12'(SETTLE_LAST) && gt_reg)
    else $error("delayed steering rose without settle delay");
  a_rx_on_ds_rise: assert property ( // RQ7
    !$stable(rx_reg) |-> $rose(ds_reg))
    else $error("receive data changed off a delayed steering edge");
  a_dv_clear_read: assert property ( // RQ14
    clk_en && stat_rd && !(gt_reg && !ds_reg && settle_reg == 12'(SETTLE_LAST)) |=> !dv_reg)
    else $error("data valid not cleared by status read");
  a_irq_needs_ds: assert property ( // RQ15
    !irq_n_reg |-> $past(ds_reg) && $past(ctrl_a_reg[dts_pkg::CA_IRQ_BIT]))
    else $error("interrupt low without delayed steering");
  a_wait_one_cycle: assert property ( // RQ18
    clk_en && req && wait_reg |=> !wait_reg)
    else $error("request not answered after one wait cycle");

  c_digit_taken: cover property ($rose(ds_reg));
  c_dropout_bridged: cover property (gt_reg && !es_reg ##1 gt_reg && es_reg);
  c_short_burst: cover property (!gt_reg && es_reg ##1 !es_reg && !gt_reg);
  c_irq_ack: cover property (!irq_n_reg ##1 stat_rd ##2 irq_n_reg);
endmodule

//--- verif/dts_tone_src.sv
// Purpose: Far-side model that sends one limited low/high tone pair as square waves.
// Assumes: Tone indices 0-3 pick the low group, 0-3 the high group.
// Notes: Both lines rest low while no pair is sent.
`timescale 1ns/1ps
module dts_tone_src #(
  parameter int SRC_CLK_HZ = dts_pkg::CLK_HZ
) (
  input wire logic ref_clk, // Bench clock
  input wire logic tone_on, // High while a pair is sent
  input wire logic [1:0] lo_idx, // Low group tone index
  input wire logic [1:0] hi_idx, // High group tone index
  output logic [1:0] tone_sq // Limited tones, 0 low group, 1 high group
);
  logic [1:0] sq_reg = 2'h0;
  logic [1:0] sq_next;
  logic [17:0] cnt_reg [2] = '{18'h0, 18'h0};
  logic [17:0] cnt_next [2];

  // Half period in clock cycles of table tone i
  function automatic logic [17:0] half(input int i);
    half = 18'(SRC_CLK_HZ / dts_pkg::TONE_HZ[i] / 2);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      cnt_next[g] = cnt_reg[g] + 18'h1;
      sq_next[g] = sq_reg[g];
      if (!tone_on) begin
        cnt_next[g] = 18'h0;
        sq_next[g] = 1'b0;
      end else if (cnt_reg[g] >= half(g == 0 ? int'(lo_idx) : int'(hi_idx) + 4) - 18'h1) begin
        cnt_next[g] = 18'h0;
        sq_next[g] = ~sq_reg[g];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    cnt_reg <= cnt_next;
    sq_reg <= sq_next;
  end

  assign tone_sq = sq_reg;
endmodule

//--- verif/test_dts_steering.sv
// Purpose: Self-checking bench for the tone receive steering block.
// Assumes: Guard counts shortened to 50 cycles; bus tasks wait for waitrequest low.
// Notes: Tone windows and the tone model assume a scaled rate to keep runs short.
`timescale 1ns/1ps
module test_dts_steering;
  localparam logic [23:0] GT_CYC = 24'h000032;
  localparam int TONE_CLK_HZ = 1_000_000;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic tone_on = 1'b0;
  logic [1:0] lo_idx = 2'h0;
  logic [1:0] hi_idx = 2'h0;
  logic [1:0] tone_sq;
  dts_pkg::dts_avs_req_s avs_req = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic early_steering;
  logic steer_in_guard_out;
  logic delayed_steering_bit;
  logic interrupt_progress_pin_n;
  int err_count = 0;
  int n_compared = 0;

  always #5 ref_clk = ~ref_clk;

  dts_steering #(.GTP_DEFAULT(GT_CYC), .GTA_DEFAULT(GT_CYC), .REF_CLK_HZ(TONE_CLK_HZ)) u_dut (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .tone_sq(tone_sq),
    .avs_req(avs_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .early_steering(early_steering), .steer_in_guard_out(steer_in_guard_out),
    .delayed_steering_bit(delayed_steering_bit),
    .interrupt_progress_pin_n(interrupt_progress_pin_n));

  dts_tone_src #(.SRC_CLK_HZ(TONE_CLK_HZ)) u_tone (.ref_clk(ref_clk), .tone_on(tone_on),
    .lo_idx(lo_idx), .hi_idx(hi_idx), .tone_sq(tone_sq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_req <= '{read: ~wr, write: wr, address: a, writedata: d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_req <= '0;
    if (n >= 20) begin
      chk(32'h1, 32'h0, "bus answer timed out");
      finish_test();
    end
  endtask

  function automatic logic sig(input int sel);
    sig = sel == 0 ? early_steering : sel == 1 ? steer_in_guard_out : delayed_steering_bit;
  endfunction

  // Bounded wait for an output level; returns cycles waited
  task automatic wait_sig(input int sel, input logic lvl, input int maxc, output int cyc);
    cyc = 0;
    do begin
      @(posedge ref_clk);
      cyc++;
    end while (sig(sel) !== lvl && cyc < maxc);
    if (cyc >= maxc) begin
      chk(32'h1, 32'h0, "output wait timed out");
      finish_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] q;
    chk({avs_waitrequest, early_steering, steer_in_guard_out, delayed_steering_bit,
         interrupt_progress_pin_n}, 32'h11, "reset outputs");
    bus(1'b0, dts_pkg::OFF_STATUS, 32'h0, q);
    chk(q, 32'h0, "status reset");
    bus(1'b0, dts_pkg::OFF_GTP, 32'h0, q);
    chk(q, 32'(GT_CYC), "present guard reset");
    bus(1'b0, dts_pkg::OFF_GTA, 32'h0, q);
    chk(q, 32'(GT_CYC), "absent guard reset");
    bus(1'b1, dts_pkg::OFF_CTRL_B, 32'hffff_fff6, q);
    bus(1'b1, dts_pkg::OFF_TX_DATA, 32'h0000_0009, q);
    bus(1'b1, 6'h1c, 32'h0000_000f, q);
    bus(1'b0, dts_pkg::OFF_CTRL_B, 32'h0, q);
    chk(q, 32'h6, "control B readback");
    bus(1'b0, dts_pkg::OFF_TX_DATA, 32'h0, q);
    chk(q, 32'h9, "tx data readback");
    bus(1'b0, 6'h1c, 32'h0, q);
    chk(q, 32'h0, "unmapped read");
    bus(1'b0, dts_pkg::OFF_RX_DATA, 32'h0, q);
    chk(q, 32'(dts_pkg::CODE_RST), "rx data reset");
  endtask

  // Valid hash pair with interrupt on, then a valid pause
  task automatic t_valid_pair();
    logic [31:0] q;
    int c;
    bus(1'b1, dts_pkg::OFF_CTRL_A, 32'h1, q);
    lo_idx <= 2'h3;
    hi_idx <= 2'h2;
    tone_on <= 1'b1;
    wait_sig(0, 1'b1, 20000, c);
    wait_sig(1, 1'b1, 200, c);
    chk(32'(c >= 48 && c <= 54), 32'h1, "guard rise delay");
    // Ten frozen cycles must not count toward the settle delay
    clk_en <= 1'b0;
    repeat (10) @(posedge ref_clk);
    clk_en <= 1'b1;
    wait_sig(2, 1'b1, 2000, c);
    chk(32'(c >= dts_pkg::SETTLE_CYC - 2 && c <= dts_pkg::SETTLE_CYC + 3), 32'h1,
        "settle delay");
    repeat (3) @(posedge ref_clk);
    chk(32'(interrupt_progress_pin_n), 32'h0, "interrupt low");
    bus(1'b0, dts_pkg::OFF_RX_DATA, 32'h0, q);
    chk(q, 32'hc, "hash code");
    bus(1'b0, dts_pkg::OFF_STATUS, 32'h0, q);
    chk(q, 32'h3c, "status with new data");
    repeat (2) @(posedge ref_clk);
    chk(32'(interrupt_progress_pin_n), 32'h1, "interrupt released");
    bus(1'b0, dts_pkg::OFF_STATUS, 32'h0, q);
    chk(q, 32'h38, "data valid cleared");
    tone_on <= 1'b0;
    wait_sig(0, 1'b0, 5000, c);
    wait_sig(1, 1'b0, 200, c);
    wait_sig(2, 1'b0, 20, c);
    bus(1'b0, dts_pkg::OFF_RX_DATA, 32'h0, q);
    chk(q, 32'hc, "code kept over pause");
  endtask

  // Star burst too short for a very long present guard
  task automatic t_short_burst();
    logic [31:0] q;
    int c;
    bus(1'b1, dts_pkg::OFF_GTP, 32'h00ff_ffff, q);
    hi_idx <= 2'h0;
    tone_on <= 1'b1;
    wait_sig(0, 1'b1, 20000, c);
    tone_on <= 1'b0;
    wait_sig(0, 1'b0, 5000, c);
    chk({steer_in_guard_out, delayed_steering_bit}, 32'h0, "burst not registered");
    bus(1'b0, dts_pkg::OFF_RX_DATA, 32'h0, q);
    chk(q, 32'hc, "rx data unchanged");
    bus(1'b1, dts_pkg::OFF_GTP, 32'(GT_CYC), q);
  endtask

  // Zero pair with interrupt off, then a dropout shorter than the absent guard
  task automatic t_dropout();
    logic [31:0] q;
    int c;
    bus(1'b1, dts_pkg::OFF_GTA, 32'h00ff_ffff, q);
    bus(1'b1, dts_pkg::OFF_CTRL_A, 32'h0, q);
    hi_idx <= 2'h1;
    tone_on <= 1'b1;
    wait_sig(2, 1'b1, 30000, c);
    repeat (3) @(posedge ref_clk);
    chk(32'(interrupt_progress_pin_n), 32'h1, "interrupt masked");
    bus(1'b0, dts_pkg::OFF_RX_DATA, 32'h0, q);
    chk(q, 32'ha, "zero code");
    tone_on <= 1'b0;
    wait_sig(0, 1'b0, 5000, c);
    repeat (100) @(posedge ref_clk);
    chk({steer_in_guard_out, delayed_steering_bit}, 32'h3, "steering held");
    bus(1'b0, dts_pkg::OFF_RX_DATA, 32'h0, q);
    chk(q, 32'ha, "data held over dropout");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_valid_pair();
    t_short_burst();
    t_dropout();
    finish_test();
  end
endmodule
